/* File: dpf_pkg.sv */
package dpf_pkg;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int NUM_PRESETS = 4;
	localparam int ADC_W = 12;
	localparam int IQ_W = 15;
	localparam int LUT_W = 8;
	localparam int MIX_W = ADC_W + LUT_W;
	localparam int ACC_W = MIX_W + 5;
	localparam int FIFO_WIDTH = 2 * IQ_W;
	localparam int FIFO_DEPTH = 16;
	localparam int DLY_AW = 7;

	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	localparam logic [3:0] PRESET_BASE_IDX = 4'h1;
	localparam logic [1:0] PHASE_WORD = 2'h0;
	localparam logic [1:0] DELAY_WORD = 2'h1;
	localparam logic [1:0] TUNING_WORD = 2'h2;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CTRL_SEL_LSB = 0;
	localparam int CTRL_DEC_LSB = 8;
	localparam int STAT_OVF_BIT = 0;
	localparam int STAT_EMPTY_BIT = 1;
	localparam int STAT_BYPASS_BIT = 2;

	// ---------------------------------------------------------------
	// Reset values and codes
	// ---------------------------------------------------------------
	localparam logic [15:0] PHASE_RESET = 16'h0000;
	localparam logic [7:0] DELAY_RESET = 8'hff;
	localparam logic [7:0] DELAY_BYPASS = 8'hff;
	localparam logic [31:0] TUNING_RESET = 32'hc0000000;
	localparam logic [5:0] DEC_MIN = 6'h04;
	localparam logic [5:0] DEC_MAX = 6'h20;
	localparam logic [5:0] DEC_RESET = 6'h04;
	localparam logic [DLY_AW-1:0] FILT_LATENCY = 7'h22;

	typedef struct packed {
		logic signed [IQ_W-1:0] i;
		logic signed [IQ_W-1:0] q;
	} dpf_iq_type;

endpackage

/* File: dpf_core.sv */
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/100ps

module dpf_fifo #(
	parameter int WIDTH = 30,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr_reg;
	logic [AW-1:0] rptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign in_ready = count_reg < (AW+1)'(DEPTH);
	assign out_valid = count_reg != '0;
	assign out_data = mem[rptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wptr_reg <= wptr_reg + 1'b1;
			end
			if (pop) begin
				rptr_reg <= rptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // dpf_fifo

module dpf_core import dpf_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic signed [ADC_W-1:0] adc_sample,
	output logic out_valid,
	input wire logic out_ready,
	output dpf_iq_type out_sample
);
	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [15:0] phase_ofs_reg [NUM_PRESETS];
	logic [7:0] fine_dly_reg [NUM_PRESETS];
	logic [31:0] tuning_reg [NUM_PRESETS];
	logic [1:0] preset_sel_reg;
	logic [5:0] dec_reg;
	logic overflow_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;

	logic acc_hit;
	logic wr_hit;
	logic [1:0] word_sel;
	logic [1:0] preset_idx;
	logic preset_hit;
	logic [31:0] rd_data;
	logic rd_ok;
	logic ovf_clear;
	logic ovf_set;
	logic fifo_empty;

	assign acc_hit = psel && penable && !pready_reg;
	assign wr_hit = psel && penable && pready_reg && pwrite && !pslverr_reg;
	assign word_sel = paddr[3:2];
	assign preset_idx = 2'(paddr[7:4] - PRESET_BASE_IDX);
	assign preset_hit = (paddr[7:4] >= PRESET_BASE_IDX)
		&& (paddr[7:4] < PRESET_BASE_IDX + 4'(NUM_PRESETS))
		&& (word_sel <= TUNING_WORD) && (paddr[1:0] == 2'h0);

	always_comb begin
		rd_data = '0;
		rd_ok = 1'b1;
		if (paddr == CTRL_ADDR) begin
			rd_data[CTRL_SEL_LSB +: 2] = preset_sel_reg;
			rd_data[CTRL_DEC_LSB +: 6] = dec_reg;
		end else if (paddr == STATUS_ADDR) begin
			rd_data[STAT_OVF_BIT] = overflow_reg;
			rd_data[STAT_EMPTY_BIT] = fifo_empty;
			rd_data[STAT_BYPASS_BIT] = fine_dly_reg[preset_sel_reg] == DELAY_BYPASS;
		end else if (preset_hit) begin
			case (word_sel)
				PHASE_WORD: rd_data[15:0] = phase_ofs_reg[preset_idx];
				DELAY_WORD: rd_data[7:0] = fine_dly_reg[preset_idx];
				TUNING_WORD: rd_data = tuning_reg[preset_idx];
				default: rd_ok = 1'b0;
			endcase
		end else begin
			rd_ok = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Bus slave: one wait state, answer registered
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
		end else if (acc_hit) begin
			pready_reg <= 1'b1;
			pslverr_reg <= !rd_ok;
			prdata_reg <= pwrite ? 32'h00000000 : rd_data;
		end else begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			preset_sel_reg <= '0;
			dec_reg <= DEC_RESET;
		end else if (wr_hit && paddr == CTRL_ADDR) begin
			preset_sel_reg <= pwdata[CTRL_SEL_LSB +: 2];
			if (pwdata[CTRL_DEC_LSB +: 8] < 8'(DEC_MIN)) begin
				dec_reg <= DEC_MIN;
			end else if (pwdata[CTRL_DEC_LSB +: 8] > 8'(DEC_MAX)) begin
				dec_reg <= DEC_MAX;
			end else begin
				dec_reg <= pwdata[CTRL_DEC_LSB +: 6];
			end
		end
	end

	genvar p;
	generate
		for (p = 0; p < NUM_PRESETS; p++) begin : g_preset
			always_ff @(posedge clk) begin
				if (rst) begin
					phase_ofs_reg[p] <= PHASE_RESET;
					fine_dly_reg[p] <= DELAY_RESET;
					tuning_reg[p] <= TUNING_RESET;
				end else if (wr_hit && preset_hit && preset_idx == 2'(p)) begin
					if (word_sel == PHASE_WORD) begin
						phase_ofs_reg[p] <= pwdata[15:0];
					end
					if (word_sel == DELAY_WORD) begin
						fine_dly_reg[p] <= pwdata[7:0];
					end
					if (word_sel == TUNING_WORD) begin
						tuning_reg[p] <= pwdata;
					end
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Oscillator and mixer
	// ---------------------------------------------------------------
	function automatic logic signed [LUT_W-1:0] cos_lut(input logic [3:0] idx);
		case (idx)
			4'h0: cos_lut = 8'sh7f;
			4'h1: cos_lut = 8'sh75;
			4'h2: cos_lut = 8'sh5a;
			4'h3: cos_lut = 8'sh31;
			4'h4: cos_lut = 8'sh00;
			4'h5: cos_lut = -8'sh31;
			4'h6: cos_lut = -8'sh5a;
			4'h7: cos_lut = -8'sh75;
			4'h8: cos_lut = -8'sh7f;
			4'h9: cos_lut = -8'sh75;
			4'ha: cos_lut = -8'sh5a;
			4'hb: cos_lut = -8'sh31;
			4'hc: cos_lut = 8'sh00;
			4'hd: cos_lut = 8'sh31;
			4'he: cos_lut = 8'sh5a;
			default: cos_lut = 8'sh75;
		endcase
	endfunction

	logic [31:0] phase_acc_reg;
	logic [31:0] phase_sum;
	logic signed [LUT_W-1:0] cos_v;
	logic signed [LUT_W-1:0] sin_v;
	logic signed [MIX_W-1:0] mix_i_reg;
	logic signed [MIX_W-1:0] mix_q_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			phase_acc_reg <= '0;
		end else begin
			phase_acc_reg <= phase_acc_reg + tuning_reg[preset_sel_reg];
		end
	end

	assign phase_sum = phase_acc_reg + {phase_ofs_reg[preset_sel_reg], 16'h0000};
	assign cos_v = cos_lut(phase_sum[31:28]);
	assign sin_v = cos_lut(phase_sum[31:28] - 4'h4);

	always_ff @(posedge clk) begin
		if (rst) begin
			mix_i_reg <= '0;
			mix_q_reg <= '0;
		end else begin
			mix_i_reg <= MIX_W'(adc_sample * cos_v);
			mix_q_reg <= MIX_W'(-(adc_sample * sin_v));
		end
	end

	// ---------------------------------------------------------------
	// Fractional delay
	// ---------------------------------------------------------------
	logic [2*MIX_W-1:0] dly_mem [2**DLY_AW];
	logic [DLY_AW-1:0] dly_wptr_reg;
	logic [7:0] cur_dly;
	logic bypass;
	logic [DLY_AW-1:0] tap_a;
	logic [DLY_AW-1:0] tap_b;
	logic signed [MIX_W:0] avg_i;
	logic signed [MIX_W:0] avg_q;
	logic signed [MIX_W-1:0] dly_i_reg;
	logic signed [MIX_W-1:0] dly_q_reg;

	assign cur_dly = fine_dly_reg[preset_sel_reg];
	assign bypass = cur_dly == DELAY_BYPASS;
	// codes above 2D-1 give no defined delay
	assign tap_a = dly_wptr_reg - 7'h01 - FILT_LATENCY - DLY_AW'(cur_dly[7:1]);
	assign tap_b = tap_a - 7'h01;
	assign avg_i = (MIX_W+1)'($signed(dly_mem[tap_a][2*MIX_W-1:MIX_W]))
		+ (MIX_W+1)'($signed(dly_mem[tap_b][2*MIX_W-1:MIX_W]));
	assign avg_q = (MIX_W+1)'($signed(dly_mem[tap_a][MIX_W-1:0]))
		+ (MIX_W+1)'($signed(dly_mem[tap_b][MIX_W-1:0]));

	// Delay line frozen when bypassed to save power
	always_ff @(posedge clk) begin
		if (!bypass) begin
			dly_mem[dly_wptr_reg] <= {mix_i_reg, mix_q_reg};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dly_wptr_reg <= '0;
		end else if (!bypass) begin
			dly_wptr_reg <= dly_wptr_reg + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dly_i_reg <= '0;
			dly_q_reg <= '0;
		end else if (bypass) begin
			dly_i_reg <= mix_i_reg;
			dly_q_reg <= mix_q_reg;
		end else if (cur_dly[0]) begin
			dly_i_reg <= avg_i[MIX_W:1];
			dly_q_reg <= avg_q[MIX_W:1];
		end else begin
			dly_i_reg <= $signed(dly_mem[tap_a][2*MIX_W-1:MIX_W]);
			dly_q_reg <= $signed(dly_mem[tap_a][MIX_W-1:0]);
		end
	end

	// ---------------------------------------------------------------
	// Decimator
	// ---------------------------------------------------------------
	logic [5:0] dec_cnt_reg;
	logic signed [ACC_W-1:0] acc_i_reg;
	logic signed [ACC_W-1:0] acc_q_reg;
	logic signed [ACC_W-1:0] sum_i;
	logic signed [ACC_W-1:0] sum_q;
	logic dump;
	dpf_iq_type dec_out_reg;
	logic dec_valid_reg;
	logic fifo_in_ready;

	assign sum_i = acc_i_reg + ACC_W'(dly_i_reg);
	assign sum_q = acc_q_reg + ACC_W'(dly_q_reg);
	assign dump = dec_cnt_reg >= dec_reg - 6'h01;

	always_ff @(posedge clk) begin
		if (rst) begin
			dec_cnt_reg <= '0;
			acc_i_reg <= '0;
			acc_q_reg <= '0;
		end else if (dump) begin
			dec_cnt_reg <= '0;
			acc_i_reg <= '0;
			acc_q_reg <= '0;
		end else begin
			dec_cnt_reg <= dec_cnt_reg + 6'h01;
			acc_i_reg <= sum_i;
			acc_q_reg <= sum_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dec_out_reg <= '0;
		end else if (dump) begin
			dec_out_reg.i <= sum_i[ACC_W-1 -: IQ_W];
			dec_out_reg.q <= sum_q[ACC_W-1 -: IQ_W];
		end
	end

	// Stream cannot stall; a full FIFO loses the older word
	assign ovf_set = dump && dec_valid_reg && !fifo_in_ready;
	assign ovf_clear = wr_hit && paddr == STATUS_ADDR && pwdata[STAT_OVF_BIT];

	always_ff @(posedge clk) begin
		if (rst) begin
			dec_valid_reg <= 1'b0;
		end else if (dump) begin
			dec_valid_reg <= 1'b1;
		end else if (fifo_in_ready) begin
			dec_valid_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			overflow_reg <= 1'b0;
		end else if (ovf_set) begin
			overflow_reg <= 1'b1;
		end else if (ovf_clear) begin
			overflow_reg <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Output buffer and register stage
	// ---------------------------------------------------------------
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [FIFO_WIDTH-1:0] fifo_out_data;
	logic out_valid_reg;
	dpf_iq_type out_sample_reg;

	dpf_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) dpf_fifo_i (
		.clk(clk),
		.rst(rst),
		.in_valid(dec_valid_reg),
		.in_ready(fifo_in_ready),
		.in_data(dec_out_reg),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	assign fifo_empty = !fifo_out_valid;
	assign fifo_out_ready = !out_valid_reg || out_ready;

	always_ff @(posedge clk) begin
		if (rst) begin
			out_valid_reg <= 1'b0;
			out_sample_reg <= '0;
		end else if (fifo_out_ready) begin
			out_valid_reg <= fifo_out_valid;
			if (fifo_out_valid) begin
				out_sample_reg <= fifo_out_data;
			end
		end
	end

	assign out_valid = out_valid_reg;
	assign out_sample = out_sample_reg;
endmodule // dpf_core

/* File: dpf_chk.sv */
`timescale 1ns/100ps
module dpf_chk import dpf_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire dpf_iq_type out_sample
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence

	a_apb_one_wait: assert property (
		s_setup ##1 s_access |-> !pready ##1 (s_access and pready))
		else $error("bus answer not after exactly one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_in_xfer: assert property (pready |-> psel && penable)
		else $error("ready outside an access");
	a_err_unmapped: assert property (pready && paddr == 8'h08 |-> pslverr)
		else $error("unmapped address not refused");
	a_err_mapped: assert property (pready && paddr == 8'h14 |-> !pslverr)
		else $error("mapped address refused");
	a_delay_width: assert property (
		pready && !pwrite && paddr == 8'h14 |-> prdata[31:8] == 24'h0)
		else $error("fine delay wider than 8 bits");
	a_phase_width: assert property (
		pready && !pwrite && paddr == 8'h10 |-> prdata[31:16] == 16'h0)
		else $error("phase offset wider than 16 bits");
	a_out_hold: assert property (
		out_valid && !out_ready |=> out_valid && $stable(out_sample))
		else $error("output sample dropped before acceptance");
	a_reset_quiet: assert property (
		$fell(rst) |-> !out_valid && !pready && out_sample == '0)
		else $error("outputs busy after reset");
endmodule // dpf_chk

bind dpf_core dpf_chk dpf_chk_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.out_valid(out_valid), .out_ready(out_ready), .out_sample(out_sample));

/* File: dpf_sink.sv */
`timescale 1ns/100ps
module dpf_sink import dpf_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic stall,
	input wire logic slow,
	input wire logic out_valid,
	output logic out_ready,
	input wire dpf_iq_type out_sample,
	output logic got,
	output dpf_iq_type got_sample
);
	logic toggle_reg;
	// Slow mode takes a word every other cycle only
	always_ff @(posedge clk) begin
		if (rst)
			toggle_reg <= 1'b0;
		else
			toggle_reg <= !toggle_reg;
	end
	assign out_ready = !rst && !stall && (!slow || toggle_reg);
	always_ff @(posedge clk) begin
		got <= !rst && out_valid && out_ready;
		got_sample <= out_sample;
	end
endmodule // dpf_sink

/* File: test_ddc_phase_offset_fractional_delay.sv */
`timescale 1ns/100ps
module test_ddc_phase_offset_fractional_delay import dpf_pkg::*;;
	typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} dpf_note_type;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, out_valid, out_ready;
	logic stall, slow, got;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r, exp;
	logic signed [ADC_W-1:0] adc_sample;
	logic [15:0] ph [4];
	logic [7:0] dl [4];
	dpf_iq_type out_sample, got_sample, s;
	dpf_note_type notes [$];
	dpf_note_type nt;
	int bad_count, samples_checked, p, k;
	int si, sq;
	logic [5:0] dec_list [5] = '{6'd2, 6'd4, 6'd17, 6'd32, 6'd40};
	logic [15:0] ofs_list [3] = '{16'h2000, 16'h0000, 16'he000};
	integer seed;

	dpf_core dpf_core_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .adc_sample(adc_sample), .out_valid(out_valid),
		.out_ready(out_ready), .out_sample(out_sample));
	dpf_sink dpf_sink_i (.clk(clk), .rst(rst), .stall(stall), .slow(slow),
		.out_valid(out_valid), .out_ready(out_ready), .out_sample(out_sample), .got(got),
		.got_sample(got_sample));

	always #20 clk = ~clk;
	always @(posedge clk) adc_sample <= 12'($random(seed));

	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic [31:0] m, input logic err);
		int n = 0;
		notes.push_back('{e & m, m, err});
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			bad_count++;
			end_sim();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic take(output dpf_iq_type t);
		int n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (got !== 1'b1 && n < 400);
		if (n >= 400) begin
			check("stream word", 32'h1, 32'h0);
			end_sim();
		end
		t = got_sample;
	endtask

	// Answers are matched in order against what the driver noted
	always @(posedge clk) begin
		if (!rst && pready === 1'b1) begin
			nt = notes.pop_front();
			check("prdata", nt.d, prdata & nt.m);
			check("pslverr", {31'h0, nt.e}, {31'h0, pslverr});
		end
	end

	initial begin
		{clk, psel, penable, pwrite, stall, slow} = '0;
		{paddr, pwdata, bad_count, samples_checked} = '0;
		rst = 1'b1;
		seed = 32'he324;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (p = 0; p < 4; p++) begin
			apb(0, 8'(16 + 16 * p), 0, {16'h0, PHASE_RESET}, '1, 0);
			apb(0, 8'(20 + 16 * p), 0, {24'h0, DELAY_RESET}, '1, 0);
			apb(0, 8'(24 + 16 * p), 0, TUNING_RESET, '1, 0);
		end
		apb(0, CTRL_ADDR, 0, 32'h400, 32'h3f03, 0);
		apb(0, STATUS_ADDR, 0, 32'h4, 32'h5, 0);
		$display("reset values done");
		for (p = 0; p < 4; p++) begin
			r = $random(seed);
			ph[p] = r[31:16];
			dl[p] = {5'h0, r[2:0]};
			apb(1, 8'(16 + 16 * p), {16'h0, ph[p]}, 0, 0, 0);
			apb(1, 8'(20 + 16 * p), {24'h0, dl[p]}, 0, 0, 0);
		end
		for (p = 0; p < 4; p++) begin
			apb(0, 8'(16 + 16 * p), 0, {16'h0, ph[p]}, '1, 0);
			apb(0, 8'(20 + 16 * p), 0, {24'h0, dl[p]}, '1, 0);
		end
		apb(0, 8'h08, 0, 0, '1, 1);
		apb(1, 8'h0c, 32'h1, 0, 0, 1);
		$display("preset registers done");
		for (k = 0; k < 5; k++) begin
			r = {26'h0, dec_list[k]};
			exp = r < 4 ? 32'h4 : (r > 32 ? 32'h20 : r);
			apb(1, CTRL_ADDR, r << 8, 0, 0, 0);
			apb(0, CTRL_ADDR, 0, exp << 8, 32'h3f00, 0);
		end
		$display("decimation range done");
		apb(1, CTRL_ADDR, 32'h401, 0, 0, 0);
		apb(0, STATUS_ADDR, 0, 32'h0, 32'h4, 0);
		apb(1, 8'h24, 32'hff, 0, 0, 0);
		apb(0, STATUS_ADDR, 0, 32'h4, 32'h4, 0);
		$display("bypass done");
		apb(1, 8'h18, 32'h0, 0, 0, 0);
		apb(1, 8'h14, 32'h2, 0, 0, 0);
		apb(1, CTRL_ADDR, 32'h400, 0, 0, 0);
		for (k = 0; k < 3; k++) begin
			r = {16'h0, ofs_list[k]};
			apb(1, 8'h10, r, 0, 0, 0);
			repeat (20) take(s);
			take(s);
			si = s.i;
			sq = s.q;
			// Truncation of a negated sum may differ by one count
			if (r[13])
				check("i and q magnitude", 32'h1, 32'(si == sq || si + sq == 0 || si + sq == -1));
			else
				check("i or q zero", 32'h1, 32'(s.i == 0 || s.q == 0));
		end
		$display("phase offset done");
		@(posedge clk);
		stall <= 1'b1;
		repeat (120) @(posedge clk);
		apb(0, STATUS_ADDR, 0, 32'h1, 32'h3, 0);
		stall <= 1'b0;
		slow <= 1'b1;
		// Let the buffer leave full before the clear, a new overflow would win
		repeat (8) @(posedge clk);
		apb(1, STATUS_ADDR, 32'h1, 0, 0, 0);
		apb(0, STATUS_ADDR, 0, 32'h0, 32'h1, 0);
		repeat (20) take(s);
		$display("buffer full and drain done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		apb(0, 8'h34, 0, 32'hff, '1, 0);
		$display("second reset done");
		repeat (4) @(posedge clk);
		end_sim();
	end
endmodule // test_ddc_phase_offset_fractional_delay
